// file: sleep_core_model.sv
// Behavioural processor core that issues sleep and runs the instruction after it.
`timescale 1ns/1ns
module sleep_core_model (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       sleep_cmd,
   input  wire logic [3:0] done_delay,
   input  wire logic       cpu_clk_en,
   input  wire logic       prefetch_req,
   output logic            sleep_instr = 1'b0,
   output logic            prefetch_done = 1'b0
);
   logic       pend_r = 1'b0;
   logic [3:0] cnt_r = 4'h0;

   // The next word executes once the clock is back.
   always @(posedge clock) begin
      sleep_instr   <= sleep_cmd && cpu_clk_en && reset_n;
      prefetch_done <= 1'b0;
      if (!reset_n) begin
         pend_r <= 1'b0;
      end else if (prefetch_req) begin
         pend_r <= 1'b1;
         cnt_r  <= done_delay;
      end else if (pend_r && cpu_clk_en) begin
         if (cnt_r == 4'h0) begin
            prefetch_done <= 1'b1;
            pend_r        <= 1'b0;
         end else begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule : sleep_core_model

// file: sleep_wake_asserts.sv
// Port checks for the sleep and wake controller.
`timescale 1ns/1ns
module sleep_wake_asserts
   import sleep_wake_pkg::*;
#(
   parameter int IO_WIDTH = 8
) (
   input wire logic                clock,
   input wire logic                reset_n,
   input wire logic                sleep_instr,
   input wire logic                prefetch_done,
   input wire reset_src_type       reset_src,
   input wire logic [IO_WIDTH-1:0] io_out,
   input wire logic [IO_WIDTH-1:0] io_oe_n,
   input wire logic                cpu_clk_en,
   input wire logic                prefetch_req,
   input wire logic                irq_vector,
   input wire logic                device_reset,
   input wire logic                low_freq_osc_en,
   input wire logic                secondary_osc_en,
   input wire logic                sense_osc_en,
   input wire logic                asleep
);
   // ----------------------------------------------------------------------
   // Sleep entry, gating and wake
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   // Sleep strobe and the gated state.
   sequence s_sleep_cmd;
      sleep_instr && !asleep && cpu_clk_en && !device_reset;
   endsequence
   sequence s_gated;
      asleep && !cpu_clk_en && prefetch_req;
   endsequence
   property p_frozen;
      asleep && $past(asleep) |-> $stable(io_out) && $stable(io_oe_n);
   endproperty

   AST_SLEEP_ENTRY: assert property (s_sleep_cmd |=> s_gated)
      else $error("late sleep");
   AST_SLEEP_CAUSE: assert property ($rose(asleep) |-> $past(sleep_instr))
      else $error("sleep without strobe");
   AST_CLOCK_GATED: assert property (asleep |-> !cpu_clk_en)
      else $error("clock running asleep");
   AST_PREFETCH: assert property (prefetch_req |-> $past(sleep_instr) ##1 !prefetch_req)
      else $error("bad prefetch");
   AST_LF_OSC: assert property (low_freq_osc_en)
      else $error("lf osc off");
   AST_SEC_OSC: assert property (secondary_osc_en)
      else $error("secondary osc off");
   AST_SENSE_OSC: assert property (sense_osc_en)
      else $error("sense osc off");
   AST_IO_FROZEN: assert property (p_frozen)
      else $error("pins moved asleep");
   AST_WAKE_RUN: assert property ($fell(asleep) && !device_reset |-> cpu_clk_en)
      else $error("wake without clock");
   AST_VECTOR: assert property (irq_vector |-> $past(prefetch_done) && !$past(irq_vector))
      else $error("bad vector");
   AST_RESET_WAKE: assert property ($rose(reset_src.brownout) |-> ##[1:6] device_reset)
      else $error("no brown-out reset");
endmodule : sleep_wake_asserts

bind sleep_wake_controller sleep_wake_asserts #(.IO_WIDTH(IO_WIDTH)) i_sleep_wake_asserts (
   .clock(clock), .reset_n(reset_n), .sleep_instr(sleep_instr),
   .prefetch_done(prefetch_done), .reset_src(reset_src), .io_out(io_out),
   .io_oe_n(io_oe_n), .cpu_clk_en(cpu_clk_en), .prefetch_req(prefetch_req),
   .irq_vector(irq_vector), .device_reset(device_reset), .low_freq_osc_en(low_freq_osc_en),
   .secondary_osc_en(secondary_osc_en), .sense_osc_en(sense_osc_en), .asleep(asleep)
);

// file: sleep_wake_controller.sv
// Sleep entry, clock gating, wake detection and watchdog.
//
// Summary of operation
// - Only the sleep strobe enters power-down.
// - Entry clears the watchdog; it runs on if enabled in sleep.
// - Entry clears the power-down flag.
// - Entry sets the time-out flag, unless the watchdog expires in the same cycle.
// - Processor clock is gated off while asleep.
// - Low-frequency internal oscillator keeps running.
// - Secondary crystal oscillator keeps running.
// - Converter on dedicated clock and sensing oscillator keep running.
// - I/O drive state is frozen while asleep.
// - Sleep changes no reset source except the watchdog.
// - Wake on reset pin, brown-out, power-on, watchdog or enabled interrupts.
// - Reset-source wake resets the device; others continue.
// - The sleep instruction prefetches the next word.
// - An interrupt wakes only if its own enable is set.
// - Interrupt wake ignores the global enable.
// - Global enable clear: resume after sleep, no vector.
// - Global enable set: execute next instruction, then vector.
// - Every wake clears the watchdog counter.
`timescale 1ns/1ns
`include "sleep_wake_defs.svh"

module sleep_wake_controller
   import sleep_wake_pkg::*;
#(
   parameter int WDT_WIDTH = `WDT_WIDTH,
   parameter int IO_WIDTH  = 8
) (
   input  wire logic                 clock,
   input  wire logic                 reset_n,
   input  wire bus_req_type          bus_req,
   output logic [7:0]                rdata,
   input  wire logic                 sleep_instr,
   input  wire logic                 prefetch_done,
   input  wire reset_src_type        reset_src,
   input  wire logic                 ext_int_pin,
   input  wire logic [7:0]           periph_flag_set_one,
   input  wire logic [7:0]           periph_flag_set_two,
   input  wire logic [IO_WIDTH-1:0]  io_out_core,
   input  wire logic [IO_WIDTH-1:0]  io_oe_n_core,
   output logic [IO_WIDTH-1:0]       io_out,
   output logic [IO_WIDTH-1:0]       io_oe_n,
   output logic                      cpu_clk_en,
   output logic                      prefetch_req,
   output logic                      irq_vector,
   output logic                      device_reset,
   output logic                      low_freq_osc_en,
   output logic                      secondary_osc_en,
   output logic                      conv_clk_en,
   output logic                      sense_osc_en,
   output logic                      asleep
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (WDT_WIDTH < 4 || WDT_WIDTH > 16) begin : g_bad_wdt
      $error("WDT_WIDTH must lie between 4 and 16");
   end
   if (IO_WIDTH < 1) begin : g_bad_io
      $error("IO_WIDTH must be at least 1");
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   // Any flag of a pair whose own enable is set.
   function automatic logic pair_hit(input logic [7:0] flags, input logic [7:0] en);
      pair_hit = |(flags & en);
   endfunction : pair_hit

   // Register write decode.
   function automatic logic wr_hit(input bus_req_type req, input logic [3:0] ofs);
      wr_hit = req.wr && (req.addr == ofs);
   endfunction : wr_hit

   // ----------------------------------------------------------------------
   // Input synchronisers for pins and asynchronous sources
   // ----------------------------------------------------------------------
   localparam int NSYNC = 4;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] s1_r;
   logic [NSYNC-1:0] s2_r;
   logic [NSYNC-1:0] s3_r;
   logic [NSYNC-1:0] clean_r;
   logic [NSYNC-1:0] clean_nxt;

   assign raw_in = {ext_int_pin, reset_src.ext_pin, reset_src.brownout, reset_src.power_on};

   // A change counts once stages two and three agree.
   genvar gi;
   for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_comb begin
         clean_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : clean_r[gi];
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s1_r    <= '0;
         s2_r    <= '0;
         s3_r    <= '0;
         clean_r <= '0;
      end else begin
         s1_r    <= raw_in;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         clean_r <= clean_nxt;
      end
   end

   logic ext_int_q;
   logic any_reset_q;
   logic ext_int_prev_r;
   assign ext_int_q   = clean_r[3];
   assign any_reset_q = |clean_r[2:0];

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [7:0]           irq_control_r,         irq_control_nxt;
   logic [7:0]           periph_irq_enable_one_r, periph_irq_enable_one_nxt;
   logic [7:0]           periph_irq_enable_two_r, periph_irq_enable_two_nxt;
   logic [7:0]           periph_irq_flags_one_r,  periph_irq_flags_one_nxt;
   logic [7:0]           periph_irq_flags_two_r,  periph_irq_flags_two_nxt;
   logic [7:0]           sleep_control_r,       sleep_control_nxt;
   logic                 timeout_flag_r,        timeout_flag_nxt;
   logic                 powerdown_flag_r,      powerdown_flag_nxt;
   logic [WDT_WIDTH-1:0] watchdog_timer_r,      watchdog_timer_nxt;
   logic [7:0]           rdata_nxt;
   power_state_type      state_r,               state_nxt;
   logic                 wake_gie_r,            wake_gie_nxt;
   logic                 wdt_expire;
   logic                 wake_req;
   logic                 sleep_enter;
   logic                 wdt_run;

   localparam logic [WDT_WIDTH-1:0] WDT_TOP = WDT_WIDTH'(`WDT_LIMIT);
   localparam int WDT_SHIFT = (WDT_WIDTH > 8) ? WDT_WIDTH - 8 : 0;

   // Wake request, global enable ignored.
   always_comb begin
      wake_req = pair_hit(irq_control_r & `IRQ_CTL_FLAG_MASK,
                          (irq_control_r & `IRQ_CTL_EN_MASK) >> 3)
               | pair_hit(periph_irq_flags_one_r, periph_irq_enable_one_r)
               | pair_hit(periph_irq_flags_two_r, periph_irq_enable_two_r);
   end

   assign sleep_enter = (state_r == st_run) && sleep_instr;
   assign wdt_run     = sleep_control_r[`BIT_WDT_ENABLE] &&
                        ((state_r != st_sleep) || sleep_control_r[`BIT_WDT_IN_SLEEP]);
   assign wdt_expire  = wdt_run && (watchdog_timer_r == WDT_TOP);

   // Register and flag next values.
   always_comb begin
      irq_control_nxt           = irq_control_r;
      periph_irq_enable_one_nxt = periph_irq_enable_one_r;
      periph_irq_enable_two_nxt = periph_irq_enable_two_r;
      periph_irq_flags_one_nxt  = periph_irq_flags_one_r;
      periph_irq_flags_two_nxt  = periph_irq_flags_two_r;
      sleep_control_nxt         = sleep_control_r;
      timeout_flag_nxt          = timeout_flag_r;
      powerdown_flag_nxt        = powerdown_flag_r;
      if (wr_hit(bus_req, `OFS_IRQ_CONTROL)) begin
         irq_control_nxt = bus_req.wdata;
      end
      if (wr_hit(bus_req, `OFS_PERIPH_EN_ONE)) begin
         periph_irq_enable_one_nxt = bus_req.wdata & `PERIPH_ONE_MASK;
      end
      if (wr_hit(bus_req, `OFS_PERIPH_EN_TWO)) begin
         periph_irq_enable_two_nxt = bus_req.wdata & `PERIPH_TWO_MASK;
      end
      if (wr_hit(bus_req, `OFS_PERIPH_FLAG_ONE)) begin
         periph_irq_flags_one_nxt = bus_req.wdata & `PERIPH_ONE_MASK;
      end
      if (wr_hit(bus_req, `OFS_PERIPH_FLAG_TWO)) begin
         periph_irq_flags_two_nxt = bus_req.wdata & `PERIPH_TWO_MASK;
      end
      if (wr_hit(bus_req, `OFS_SLEEP_CONTROL)) begin
         sleep_control_nxt = bus_req.wdata & 8'h07;
      end
      // Hardware sets follow the write so they win.
      periph_irq_flags_one_nxt = periph_irq_flags_one_nxt | (periph_flag_set_one & `PERIPH_ONE_MASK);
      periph_irq_flags_two_nxt = periph_irq_flags_two_nxt | (periph_flag_set_two & `PERIPH_TWO_MASK);
      if (ext_int_q && !ext_int_prev_r) begin
         irq_control_nxt[1] = 1'b1;
      end
      if (sleep_enter) begin
         powerdown_flag_nxt = 1'b0;
         timeout_flag_nxt   = 1'b1;
      end
      if (wdt_expire) begin
         timeout_flag_nxt = 1'b0;
      end
   end

   // Power states: run, gated sleep, one-cycle wake.
   always_comb begin
      state_nxt    = state_r;
      wake_gie_nxt = wake_gie_r;
      case (state_r)
         st_run: begin
            if (sleep_enter) begin
               state_nxt = st_sleep;
            end
         end
         st_sleep: begin
            // Sampled every cycle while the core clock is off.
            if (wake_req || wdt_expire) begin
               state_nxt    = st_wake;
               wake_gie_nxt = irq_control_r[`BIT_GLOBAL_IRQ_EN] && wake_req;
            end
         end
         st_wake: begin
            state_nxt = st_run;
         end
         default: begin
            state_nxt = st_run;
         end
      endcase
   end

   // Watchdog, cleared on entry and on every wake.
   always_comb begin
      watchdog_timer_nxt = watchdog_timer_r;
      if (sleep_enter || state_r == st_wake) begin
         watchdog_timer_nxt = '0;
      end else if (wdt_run) begin
         watchdog_timer_nxt = wdt_expire ? '0 : watchdog_timer_r + 1'b1;
      end
   end

   // Read mux, answered in the cycle after the strobe.
   always_comb begin
      rdata_nxt = 8'h00;
      if (bus_req.rd) begin
         case (bus_req.addr)
            `OFS_IRQ_CONTROL:     rdata_nxt = irq_control_r;
            `OFS_PERIPH_EN_ONE:   rdata_nxt = periph_irq_enable_one_r;
            `OFS_PERIPH_EN_TWO:   rdata_nxt = periph_irq_enable_two_r;
            `OFS_PERIPH_FLAG_ONE: rdata_nxt = periph_irq_flags_one_r;
            `OFS_PERIPH_FLAG_TWO: rdata_nxt = periph_irq_flags_two_r;
            `OFS_CORE_STATUS: begin
               rdata_nxt[`BIT_TIMEOUT_FLAG]   = timeout_flag_r;
               rdata_nxt[`BIT_POWERDOWN_FLAG] = powerdown_flag_r;
            end
            `OFS_SLEEP_CONTROL:   rdata_nxt = sleep_control_r;
            `OFS_WATCHDOG_COUNT:  rdata_nxt = 8'(watchdog_timer_r >> WDT_SHIFT);
            default:              rdata_nxt = 8'h00;
         endcase
      end
   end

   // Core control outputs, registered.
   logic                cpu_clk_en_nxt;
   logic                prefetch_req_nxt;
   logic                irq_vector_nxt;
   logic                device_reset_nxt;
   logic                conv_clk_en_nxt;
   logic [IO_WIDTH-1:0] io_out_nxt;
   logic [IO_WIDTH-1:0] io_oe_n_nxt;
   logic                vector_pending_r, vector_pending_nxt;

   always_comb begin
      cpu_clk_en_nxt     = (state_nxt != st_sleep);
      prefetch_req_nxt   = sleep_enter;
      vector_pending_nxt = vector_pending_r;
      irq_vector_nxt     = 1'b0;
      if (state_r == st_wake && wake_gie_r) begin
         vector_pending_nxt = 1'b1;
      end else if (vector_pending_r && prefetch_done) begin
         vector_pending_nxt = 1'b0;
         irq_vector_nxt     = 1'b1;
      end
      // No global enable: resume at the prefetched word.
      device_reset_nxt   = any_reset_q;
      conv_clk_en_nxt    = (state_nxt != st_sleep) || sleep_control_r[`BIT_CONV_DEDICATED];
      // Pins follow the core, frozen while asleep.
      io_out_nxt  = (state_nxt == st_sleep) ? io_out  : io_out_core;
      io_oe_n_nxt = (state_nxt == st_sleep) ? io_oe_n : io_oe_n_core;
   end

   // State registers; a reset-source wake restarts all.
   always_ff @(posedge clock) begin
      if (!reset_n || any_reset_q) begin
         irq_control_r           <= `RST_IRQ_CONTROL;
         periph_irq_enable_one_r <= `RST_PERIPH;
         periph_irq_enable_two_r <= `RST_PERIPH;
         periph_irq_flags_one_r  <= `RST_PERIPH;
         periph_irq_flags_two_r  <= `RST_PERIPH;
         sleep_control_r         <= `RST_SLEEP_CONTROL;
         timeout_flag_r          <= 1'(`RST_CORE_STATUS >> `BIT_TIMEOUT_FLAG);
         powerdown_flag_r        <= 1'(`RST_CORE_STATUS >> `BIT_POWERDOWN_FLAG);
         watchdog_timer_r        <= '0;
         state_r                 <= st_run;
         wake_gie_r              <= 1'b0;
         vector_pending_r        <= 1'b0;
         ext_int_prev_r          <= 1'b0;
         cpu_clk_en              <= 1'b1;
         prefetch_req            <= 1'b0;
         irq_vector              <= 1'b0;
         conv_clk_en             <= 1'b1;
         io_out                  <= '0;
         io_oe_n                 <= '1;
         asleep                  <= 1'b0;
      end else begin
         irq_control_r           <= irq_control_nxt;
         periph_irq_enable_one_r <= periph_irq_enable_one_nxt;
         periph_irq_enable_two_r <= periph_irq_enable_two_nxt;
         periph_irq_flags_one_r  <= periph_irq_flags_one_nxt;
         periph_irq_flags_two_r  <= periph_irq_flags_two_nxt;
         sleep_control_r         <= sleep_control_nxt;
         timeout_flag_r          <= timeout_flag_nxt;
         powerdown_flag_r        <= powerdown_flag_nxt;
         watchdog_timer_r        <= watchdog_timer_nxt;
         state_r                 <= state_nxt;
         wake_gie_r              <= wake_gie_nxt;
         vector_pending_r        <= vector_pending_nxt;
         ext_int_prev_r          <= ext_int_q;
         cpu_clk_en              <= cpu_clk_en_nxt;
         prefetch_req            <= prefetch_req_nxt;
         irq_vector              <= irq_vector_nxt;
         conv_clk_en             <= conv_clk_en_nxt;
         io_out                  <= io_out_nxt;
         io_oe_n                 <= io_oe_n_nxt;
         asleep                  <= (state_nxt == st_sleep);
      end
   end

   // Outputs that must survive every reset source.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         rdata            <= 8'h00;
         device_reset     <= 1'b0;
         low_freq_osc_en  <= 1'b1;
         secondary_osc_en <= 1'b1;
         sense_osc_en     <= 1'b1;
      end else begin
         rdata            <= rdata_nxt;
         device_reset     <= device_reset_nxt;
         low_freq_osc_en  <= 1'b1;
         secondary_osc_en <= 1'b1;
         sense_osc_en     <= 1'b1;
      end
   end

endmodule : sleep_wake_controller

// file: sleep_wake_controller_tb_top.sv
// Self-checking bench for the sleep and wake controller.
`timescale 1ns/1ns
`include "sleep_wake_defs.svh"
module sleep_wake_controller_tb_top
   import sleep_wake_pkg::*;
   ;
   logic          clock = 1'b0, reset_n = 1'b0, sleep_cmd = 1'b0, ext_int_pin = 1'b0;
   logic          sleep_instr, prefetch_done, cpu_clk_en, prefetch_req, irq_vector;
   logic          device_reset, low_freq_osc_en, secondary_osc_en, conv_clk_en;
   logic          sense_osc_en, asleep;
   bus_req_type   bus_req = '0;
   reset_src_type reset_src = '0;
   logic [7:0]    rdata, io_out, io_oe_n, flag_one = 8'h00;
   logic [7:0]    io_out_core = 8'h00, io_oe_n_core = 8'hFF;
   logic [3:0]    done_delay = 4'h1;
   int            n_errors = 0, tests_run = 0, cycles = 0;

   sleep_wake_controller #(.WDT_WIDTH(5), .IO_WIDTH(8)) i_sleep_wake_controller (
      .clock(clock), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
      .sleep_instr(sleep_instr), .prefetch_done(prefetch_done), .reset_src(reset_src),
      .ext_int_pin(ext_int_pin), .periph_flag_set_one(flag_one),
      .periph_flag_set_two(8'h00), .io_out_core(io_out_core), .io_oe_n_core(io_oe_n_core),
      .io_out(io_out), .io_oe_n(io_oe_n), .cpu_clk_en(cpu_clk_en),
      .prefetch_req(prefetch_req), .irq_vector(irq_vector), .device_reset(device_reset),
      .low_freq_osc_en(low_freq_osc_en), .secondary_osc_en(secondary_osc_en),
      .conv_clk_en(conv_clk_en), .sense_osc_en(sense_osc_en), .asleep(asleep));
   sleep_core_model i_sleep_core_model (
      .clock(clock), .reset_n(reset_n), .sleep_cmd(sleep_cmd), .done_delay(done_delay),
      .cpu_clk_en(cpu_clk_en), .prefetch_req(prefetch_req), .sleep_instr(sleep_instr),
      .prefetch_done(prefetch_done));

   // ----------------------------------------------------------------------
   // Clock, hang guard and reporting
   // ----------------------------------------------------------------------
   always #25 clock = ~clock;
   // Trips only on a hang.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         n_errors++;
         final_report;
      end
   end
   // Counts, verdict, stop.
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // Compare helpers.
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check_byte
   task automatic check_bit(input string what, input logic exp, input logic got);
      check_byte(what, {7'h00, exp}, {7'h00, got});
   endtask : check_bit

   // ----------------------------------------------------------------------
   // Bus and sleep helpers
   // ----------------------------------------------------------------------
   // Strobes last one cycle.
   task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus_req <= '0;
      @(posedge clock);
   endtask : bus_write
   task automatic read_check(input logic [3:0] a, input logic [7:0] exp, input string what);
      logic [7:0] got;
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus_req <= '0;
      #1;
      got = rdata;
      @(posedge clock);
      check_byte(what, exp, got);
   endtask : read_check
   // Sleep via the core, then check gating and status.
   task automatic enter_sleep;
      sleep_cmd <= 1'b1;
      @(posedge clock);
      sleep_cmd <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check_bit("asleep", 1'b1, asleep);
      check_bit("cpu_clk_en", 1'b0, cpu_clk_en);
      @(posedge clock);
      read_check(`OFS_CORE_STATUS, 8'h10, "core status in sleep");
   endtask : enter_sleep
   task automatic wait_wake(input int limit);
      int n;
      n = 0;
      #1;
      while (asleep === 1'b1 && n < limit) begin
         @(posedge clock);
         #1;
         n++;
      end
      check_bit("asleep after wake", 1'b0, asleep);
      @(posedge clock);
   endtask : wait_wake
   task automatic watch_vector(input int n, input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge clock);
         #1;
         if (irq_vector === 1'b1) seen = 1'b1;
      end
      check_bit("irq_vector", exp, seen);
      @(posedge clock);
   endtask : watch_vector
   task automatic clear_irqs;
      bus_write(`OFS_IRQ_CONTROL, 8'h00);
      bus_write(`OFS_PERIPH_FLAG_ONE, 8'h00);
      bus_write(`OFS_PERIPH_EN_ONE, 8'h00);
   endtask : clear_irqs

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Reset values, read-only status, unmapped place.
   task automatic test_regs;
      for (int a = 0; a < 5; a++) read_check(4'(a), 8'h00, "irq register reset");
      bus_write(`OFS_CORE_STATUS, 8'h00);
      read_check(`OFS_CORE_STATUS, `RST_CORE_STATUS, "core status read only");
      bus_write(4'hF, 8'hFF);
      read_check(4'hF, 8'h00, "unmapped");
      bus_write(`OFS_PERIPH_EN_ONE, 8'h01);
      read_check(`OFS_PERIPH_EN_ONE, 8'h01, "periph enable one");
   endtask : test_regs
   // Peripheral wake, global enable clear; masked pin.
   task automatic test_periph_wake;
      bus_write(`OFS_SLEEP_CONTROL, 8'h04);
      io_out_core  <= 8'hA5;
      io_oe_n_core <= 8'h0F;
      repeat (2) @(posedge clock);
      enter_sleep;
      io_out_core  <= 8'h5A;
      io_oe_n_core <= 8'hF0;
      ext_int_pin  <= 1'b1;
      repeat (10) @(posedge clock);
      #1;
      check_bit("asleep pin masked", 1'b1, asleep);
      check_byte("io_out", 8'hA5, io_out);
      check_byte("io_oe_n", 8'h0F, io_oe_n);
      check_bit("conv_clk_en", 1'b1, conv_clk_en);
      check_bit("low_freq_osc_en", 1'b1, low_freq_osc_en);
      check_bit("secondary_osc_en", 1'b1, secondary_osc_en);
      @(posedge clock);
      ext_int_pin <= 1'b0;
      flag_one    <= 8'h01;
      @(posedge clock);
      flag_one <= 8'h00;
      wait_wake(4);
      watch_vector(16, 1'b0);
   endtask : test_periph_wake
   // Pin wake, global enable set, slow core: late vector.
   task automatic test_pin_vector;
      clear_irqs;
      bus_write(`OFS_SLEEP_CONTROL, 8'h00);
      bus_write(`OFS_IRQ_CONTROL, 8'h90);
      done_delay <= 4'h6;
      enter_sleep;
      #1;
      check_bit("conv_clk_en", 1'b0, conv_clk_en);
      @(posedge clock);
      ext_int_pin <= 1'b1;
      wait_wake(10);
      ext_int_pin <= 1'b0;
      watch_vector(16, 1'b1);
   endtask : test_pin_vector
   // Watchdog wake clears the time-out flag.
   task automatic test_watchdog_wake;
      clear_irqs;
      bus_write(`OFS_SLEEP_CONTROL, 8'h03);
      enter_sleep;
      wait_wake(80);
      bus_write(`OFS_SLEEP_CONTROL, 8'h00);
      read_check(`OFS_CORE_STATUS, 8'h00, "core status after watchdog");
   endtask : test_watchdog_wake
   // Brown-out in sleep resets the device.
   task automatic test_brownout_wake;
      enter_sleep;
      reset_src.brownout <= 1'b1;
      repeat (8) @(posedge clock);
      #1;
      check_bit("device_reset", 1'b1, device_reset);
      check_bit("asleep", 1'b0, asleep);
      @(posedge clock);
      reset_src.brownout <= 1'b0;
      repeat (8) @(posedge clock);
      read_check(`OFS_CORE_STATUS, `RST_CORE_STATUS, "core status after reset");
   endtask : test_brownout_wake

   // Main sequence.
   initial begin
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      test_regs;
      test_periph_wake;
      test_pin_vector;
      test_watchdog_wake;
      test_brownout_wake;
      final_report;
   end
endmodule : sleep_wake_controller_tb_top

// file: sleep_wake_defs.svh
// Offsets, field positions, reset values and timing counts of the sleep and wake controller.
`ifndef SLEEP_WAKE_DEFS_SVH
`define SLEEP_WAKE_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_IRQ_CONTROL      4'h0
`define OFS_PERIPH_EN_ONE    4'h1
`define OFS_PERIPH_EN_TWO    4'h2
`define OFS_PERIPH_FLAG_ONE  4'h3
`define OFS_PERIPH_FLAG_TWO  4'h4
`define OFS_CORE_STATUS      4'h5
`define OFS_SLEEP_CONTROL    4'h6
`define OFS_WATCHDOG_COUNT   4'h7

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define BIT_GLOBAL_IRQ_EN    7
`define BIT_PERIPH_IRQ_EN    6
`define IRQ_CTL_EN_MASK      8'h38
`define IRQ_CTL_FLAG_MASK    8'h07
`define PERIPH_ONE_MASK      8'hC1
`define PERIPH_TWO_MASK      8'h04
`define BIT_TIMEOUT_FLAG     4
`define BIT_POWERDOWN_FLAG   3
`define BIT_WDT_ENABLE       0
`define BIT_WDT_IN_SLEEP     1
`define BIT_CONV_DEDICATED   2

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define RST_IRQ_CONTROL      8'h00
`define RST_PERIPH           8'h00
`define RST_CORE_STATUS      8'h18
`define RST_SLEEP_CONTROL    8'h00
`define WDT_WIDTH            16
`define WDT_LIMIT            16'hFFFF

`endif

// file: sleep_wake_pkg.sv
// Types shared by the sleep and wake controller.
package sleep_wake_pkg;

   // Power states, one-hot.
   typedef enum logic [2:0] {
      st_run   = 3'b001,
      st_sleep = 3'b010,
      st_wake  = 3'b100
   } power_state_type;

   // Register bus request carrier.
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_type;

   // Reset sources that bypass the sleep logic.
   typedef struct packed {
      logic ext_pin;
      logic brownout;
      logic power_on;
   } reset_src_type;

endpackage : sleep_wake_pkg
